// File: core/fom_pkg.sv
// constants, enumerations and carrier structs of the flow output mapping block
// assumes one 200 MHz clock; all flow values arrive in the internal unit (volume/h)
package fom_pkg;
	localparam int          CLK_PERIOD_PS  = 5000;       // 200 MHz
	localparam int          TICK_TIME_US   = 1000;       // damping and delay tick, 1 ms
	localparam int          TICK_CYC       = (TICK_TIME_US * 1000000) / CLK_PERIOD_PS;
	localparam int          MS_PER_S       = 1000;
	localparam logic [5:0]  DELAY_MAX_S    = 6'h3C;      // 60 s
	localparam logic [3:0]  PULSE_HOLD_MS  = 4'hA;       // width of a volume pulse
	localparam logic [31:0] DISP_MAX       = 32'h0000_270F; // 9999
	localparam logic [31:0] SEC_PER_MIN    = 32'h0000_003C;
	localparam logic [31:0] SEC_PER_H      = 32'h0000_0E10;
	localparam logic [15:0] CUR_4MA_UA     = 16'h0FA0;   // 4000 uA
	localparam logic [15:0] CUR_20MA_UA    = 16'h4E20;   // 20000 uA
	localparam logic [15:0] CUR_22MA_UA    = 16'h55F0;   // 22000 uA
	localparam logic [15:0] CUR_SPAN_UA    = 16'h3E80;   // 16000 uA
	localparam logic [63:0] PULSE_VOL_ONE  = 64'h0000_0000_0000_03E8; // volume in 1/1000
	localparam logic [63:0] PULSE_PROD_MAX = 64'h0000_0000_3B9A_CA00; // 1000000 scaled
	localparam int          DAMP_FAST_SH   = 3;
	localparam int          DAMP_SLOW_SH   = 6;
	localparam logic [31:0] MINMAX_RST_MIN = 32'hFFFF_FFFF;
	localparam logic [31:0] MINMAX_RST_MAX = 32'h0000_0000;

	typedef enum logic [2:0] {SRC_FLOW, SRC_FREQ, SRC_TOT1, SRC_TOT2, SRC_WARN} fom_src_e;
	typedef enum logic [1:0] {TU_S, TU_MIN, TU_H} fom_tunit_e;
	typedef enum logic [1:0] {DAMP_NONE, DAMP_FAST, DAMP_SLOW} fom_damp_e;
	typedef enum logic [1:0] {SW_HYST, SW_WINDOW, SW_PULSE} fom_swmode_e;

	// one current output setting
	typedef struct packed {
		fom_src_e    src;
		fom_tunit_e  tunit;      // time unit of the two range values
		logic [31:0] p_4ma;
		logic [31:0] p_20ma;
		fom_damp_e   damp;
		logic        diag_en;    // diag_current_option
	} fom_cur_cfg_s;

	// one switch output setting
	typedef struct packed {
		fom_src_e    src;
		fom_swmode_e mode;
		fom_tunit_e  tunit;
		logic [31:0] low;
		logic [31:0] high;
		logic        nc;         // rest sense normally closed
		logic [5:0]  delay_s;
		logic [31:0] pulse_vol;  // volume per pulse, 1/1000 units
	} fom_sw_cfg_s;

	// input frequency monitor
	typedef struct packed {
		logic        en;
		logic [31:0] warn_hi;
		logic [31:0] warn_lo;
		logic [31:0] err_hi;
		logic [31:0] err_lo;
	} fom_mon_cfg_s;

	// display line or min/max selection
	typedef struct packed {
		logic        en;
		fom_src_e    src;
		fom_tunit_e  tunit;
	} fom_disp_cfg_s;
endpackage

// File: core/fom_switch.sv
// one switch output: threshold, window, warning or volume-pulse operation
// assumes thresholds already in the internal unit and a 1 ms tick pulse
`timescale 1ns/1ps
module fom_switch (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 tick,
	input  wire fom_pkg::fom_sw_cfg_s cfg,
	input  wire logic [31:0]          value,      // selected source, internal unit
	input  wire logic [31:0]          low,
	input  wire logic [31:0]          high,
	input  wire logic                 warn,
	input  wire logic                 sens_level,
	input  wire logic                 sens_rise,
	input  wire logic [31:0]          ratio,      // sensor pulses per output pulse
	input  wire logic                 forced,
	output logic                      sw_out
);
	logic        active;      // switch engaged
	logic        next_active;
	logic [15:0] cnt;         // delay counter in ms
	logic [15:0] next_cnt;
	logic [31:0] pcnt;        // sensor pulses since last output pulse
	logic [31:0] next_pcnt;
	logic [3:0]  hold;        // remaining ms of current pulse
	logic [3:0]  next_hold;
	logic        target;
	logic [15:0] delay_ms;

	// next state of the switch
	always_comb begin
		next_active = active;
		next_cnt    = cnt;
		next_pcnt   = pcnt;
		next_hold   = hold;
		target      = active;
		delay_ms    = 16'(cfg.delay_s * fom_pkg::MS_PER_S);
		if (cfg.src == fom_pkg::SRC_WARN) begin
			next_active = warn;
			next_cnt    = '0;
		end else if (cfg.mode == fom_pkg::SW_PULSE) begin
			next_cnt = '0;
			if (forced) begin
				next_active = sens_level;
			end else begin
				if (tick && hold != '0) begin
					next_hold = hold - 4'h1;
				end
				if (tick && hold == 4'h1) begin
					next_active = 1'b0;
				end
				if (sens_rise) begin
					if (pcnt + 32'h0000_0001 >= ratio) begin
						next_pcnt   = '0;
						next_active = 1'b1;
						next_hold   = fom_pkg::PULSE_HOLD_MS;
					end else begin
						next_pcnt = pcnt + 32'h0000_0001;
					end
				end
			end
		end else begin
			// threshold modes share the delay counter below
			if (cfg.mode == fom_pkg::SW_HYST) begin
				if (value >= high) begin
					target = 1'b1;
				end else if (value <= low) begin
					target = 1'b0;
				end
			end else begin
				target = (value >= low) && (value <= high);
			end
			if (target == active) begin
				next_cnt = '0;
			end else if (tick) begin
				if (cnt >= delay_ms) begin
					next_active = target;
					next_cnt    = '0;
				end else begin
					next_cnt = cnt + 16'h0001;
				end
			end
		end
	end

	// registers; pin level set by rest sense
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			active <= 1'b0;
			cnt    <= '0;
			pcnt   <= '0;
			hold   <= '0;
			sw_out <= 1'b0;
		end else begin
			active <= next_active;
			cnt    <= next_cnt;
			pcnt   <= next_pcnt;
			hold   <= next_hold;
			sw_out <= next_active ^ cfg.nc;
		end
	end

	AST_SW_WARN: assert property (@(posedge clk) disable iff (!rstn)
		(cfg.src == fom_pkg::SRC_WARN && warn) |=> (sw_out == !$past(cfg.nc)))
		else $error("switch did not follow warning in one cycle");

	AST_SW_SENSE: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> (sw_out == (active ^ $past(cfg.nc))))
		else $error("switch pin disagrees with rest sense");

	AST_SW_NO_EARLY: assert property (@(posedge clk) disable iff (!rstn)
		(cfg.src != fom_pkg::SRC_WARN && cfg.mode != fom_pkg::SW_PULSE && !tick)
		|=> $stable(active))
		else $error("threshold switch changed between ticks");
endmodule

// File: core/fom_output_map.sv
// flow output mapping top: display limits, min/max, current outputs, switch outputs
// assumes all inputs synchronous to clk; flow in volume units per hour
`timescale 1ns/1ps
module fom_output_map #(
	parameter int TICK_CYCLES = fom_pkg::TICK_CYC     // cycles per 1 ms tick
) (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic [31:0]            flow_rate,
	input  wire logic [31:0]            input_freq,
	input  wire logic [31:0]            total_one,
	input  wire logic [31:0]            total_two,
	input  wire logic                   sensor_in,   // sensor pulse level
	input  wire logic [31:0]            k_factor,
	input  wire logic                   device_fault,
	input  wire fom_pkg::fom_mon_cfg_s  freq_mon,
	input  wire fom_pkg::fom_disp_cfg_s disp_cfg,
	input  wire fom_pkg::fom_disp_cfg_s minmax_cfg,
	input  wire logic                   minmax_clear,
	input  wire logic [6:0]             contrast,
	input  wire logic [6:0]             backlight,
	input  wire logic                   output_wiring_select, // 0 sink, 1 source unless npn_variant
	input  wire logic                   npn_variant,
	input  wire fom_pkg::fom_cur_cfg_s  cur_cfg_one,
	input  wire fom_pkg::fom_cur_cfg_s  cur_cfg_two,
	input  wire fom_pkg::fom_sw_cfg_s   sw_cfg_one,
	input  wire fom_pkg::fom_sw_cfg_s   sw_cfg_two,
	output logic [31:0]                 display_value,
	output logic [31:0]                 min_value,
	output logic [31:0]                 max_value,
	output logic                        minmax_shown,
	output logic [6:0]                  disp_contrast,
	output logic [6:0]                  disp_backlight,
	output logic                        wiring_sink,
	output logic [15:0]                 current_output_one,
	output logic [15:0]                 current_output_two,
	output logic                        switch_output_one,
	output logic                        switch_output_two,
	output logic                        warning_event,
	output logic                        error_event,
	output logic [1:0]                  pulse_setting_too_large_warning,
	output logic [1:0]                  pulse_setting_forced_warning
);
	// convert a user value in a time unit into the internal per-hour unit
	function automatic logic [31:0] to_int(input logic [31:0] v, input fom_pkg::fom_tunit_e tu,
		input fom_pkg::fom_src_e src);
		to_int = v;
		if (src == fom_pkg::SRC_FLOW && tu == fom_pkg::TU_S) begin
			to_int = 32'(v * fom_pkg::SEC_PER_H);
		end else if (src == fom_pkg::SRC_FLOW && tu == fom_pkg::TU_MIN) begin
			to_int = 32'(v * fom_pkg::SEC_PER_MIN);
		end
	endfunction

	// internal value into a displayed figure limited to four digits
	function automatic logic [31:0] to_disp(input logic [31:0] v, input fom_pkg::fom_tunit_e tu,
		input fom_pkg::fom_src_e src);
		logic [31:0] d;
		d = v;
		if (src == fom_pkg::SRC_FLOW && tu == fom_pkg::TU_S) begin
			d = v / fom_pkg::SEC_PER_H;
		end else if (src == fom_pkg::SRC_FLOW && tu == fom_pkg::TU_MIN) begin
			d = v / fom_pkg::SEC_PER_MIN;
		end
		to_disp = (d > fom_pkg::DISP_MAX) ? fom_pkg::DISP_MAX : d;
	endfunction

	// selected measurement
	function automatic logic [31:0] pick(input fom_pkg::fom_src_e src, input logic [31:0] f,
		input logic [31:0] q, input logic [31:0] t1, input logic [31:0] t2);
		case (src)
			fom_pkg::SRC_FREQ: pick = q;
			fom_pkg::SRC_TOT1: pick = t1;
			fom_pkg::SRC_TOT2: pick = t2;
			default:           pick = f;
		endcase
	endfunction

	logic [17:0] tick_cnt;    // ms divider
	logic [17:0] next_tick_cnt;
	logic        tick;
	logic        next_tick;
	logic        sens_d;      // previous sensor level
	logic        sens_rise;

	// 1 ms tick divider
	always_comb begin
		next_tick_cnt = tick_cnt + 18'h0_0001;
		next_tick     = 1'b0;
		if (tick_cnt >= 18'(TICK_CYCLES - 1)) begin
			next_tick_cnt = '0;
			next_tick     = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
			sens_d   <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick     <= next_tick;
			sens_d   <= sensor_in;
		end
	end
	assign sens_rise = sensor_in && !sens_d;

	// ---- events, wiring, display settings ----
	logic        next_warn;
	logic        next_err;
	logic        next_sink;
	logic [63:0] prod [2];    // pulse volume times k-factor
	logic [1:0]  next_big;
	logic [1:0]  next_forced;
	logic [31:0] ratio [2];   // sensor pulses per output pulse
	logic [31:0] next_ratio [2];

	always_comb begin
		prod[0]     = 64'(sw_cfg_one.pulse_vol) * 64'(k_factor);
		prod[1]     = 64'(sw_cfg_two.pulse_vol) * 64'(k_factor);
		next_big    = '0;
		next_forced = '0;
		for (int i = 0; i < 2; i++) begin
			next_big[i]    = prod[i] > fom_pkg::PULSE_PROD_MAX;
			next_forced[i] = prod[i] < fom_pkg::PULSE_VOL_ONE;
			next_ratio[i]  = 32'(prod[i] / fom_pkg::PULSE_VOL_ONE);
		end
		if (sw_cfg_one.mode != fom_pkg::SW_PULSE) begin
			next_big[0]    = 1'b0;
			next_forced[0] = 1'b0;
		end
		if (sw_cfg_two.mode != fom_pkg::SW_PULSE) begin
			next_big[1]    = 1'b0;
			next_forced[1] = 1'b0;
		end
		next_warn = (freq_mon.en && (input_freq > freq_mon.warn_hi ||
			input_freq < freq_mon.warn_lo)) || (|next_big) || (|next_forced);
		next_err  = freq_mon.en && (input_freq > freq_mon.err_hi ||
			input_freq < freq_mon.err_lo);
		next_sink = !output_wiring_select || npn_variant;
	end

	// contrast and backlight are held here only and never join an upload image
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			warning_event                   <= 1'b0;
			error_event                     <= 1'b0;
			wiring_sink                     <= 1'b1;
			pulse_setting_too_large_warning <= '0;
			pulse_setting_forced_warning    <= '0;
			ratio                           <= '{default: '0};
			disp_contrast                   <= '0;
			disp_backlight                  <= '0;
		end else begin
			warning_event                   <= next_warn;
			error_event                     <= next_err;
			wiring_sink                     <= next_sink;
			pulse_setting_too_large_warning <= next_big;
			pulse_setting_forced_warning    <= next_forced;
			ratio                           <= next_ratio;
			disp_contrast                   <= contrast;
			disp_backlight                  <= backlight;
		end
	end

	// ---- display and min/max ----
	logic [31:0] mm_val;
	logic [31:0] mn;          // minimum, internal unit
	logic [31:0] mx;          // maximum, internal unit
	logic [31:0] next_mn;
	logic [31:0] next_mx;

	always_comb begin
		mm_val  = pick(minmax_cfg.src, flow_rate, input_freq, total_one, total_two);
		next_mn = (mm_val < mn) ? mm_val : mn;
		next_mx = (mm_val > mx) ? mm_val : mx;
		if (minmax_clear) begin
			next_mn = fom_pkg::MINMAX_RST_MIN;
			next_mx = fom_pkg::MINMAX_RST_MAX;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mn            <= fom_pkg::MINMAX_RST_MIN;
			mx            <= fom_pkg::MINMAX_RST_MAX;
			min_value     <= '0;
			max_value     <= '0;
			minmax_shown  <= 1'b0;
			display_value <= '0;
		end else begin
			mn            <= next_mn;
			mx            <= next_mx;
			min_value     <= minmax_cfg.en ? to_disp(next_mn, minmax_cfg.tunit,
				minmax_cfg.src) : '0;
			max_value     <= minmax_cfg.en ? to_disp(next_mx, minmax_cfg.tunit,
				minmax_cfg.src) : '0;
			minmax_shown  <= minmax_cfg.en;
			display_value <= to_disp(pick(disp_cfg.src, flow_rate, input_freq, total_one,
				total_two), disp_cfg.tunit, disp_cfg.src);
		end
	end

	// ---- current outputs ----
	fom_pkg::fom_cur_cfg_s ccfg [2];
	logic [31:0]           damp [2];      // damped source value
	logic [31:0]           next_damp [2];
	logic [15:0]           next_cur [2];
	logic signed [33:0]    diff;
	logic signed [33:0]    p1;
	logic signed [33:0]    p2;
	logic signed [63:0]    q;
	logic [31:0]           raw;

	always_comb begin
		ccfg[0] = cur_cfg_one;
		ccfg[1] = cur_cfg_two;
		diff    = '0;
		p1      = '0;
		p2      = '0;
		q       = '0;
		raw     = '0;
		for (int i = 0; i < 2; i++) begin
			raw          = pick(ccfg[i].src, flow_rate, input_freq, total_one, total_two);
			diff         = 34'(signed'({2'b00, raw})) - 34'(signed'({2'b00, damp[i]}));
			next_damp[i] = damp[i];
			if (ccfg[i].damp == fom_pkg::DAMP_NONE) begin
				next_damp[i] = raw;
			end else if (tick && ccfg[i].damp == fom_pkg::DAMP_FAST) begin
				next_damp[i] = 32'(34'(signed'({2'b00, damp[i]})) + (diff >>> fom_pkg::DAMP_FAST_SH));
			end else if (tick) begin
				next_damp[i] = 32'(34'(signed'({2'b00, damp[i]})) + (diff >>> fom_pkg::DAMP_SLOW_SH));
			end
			p1 = signed'({2'b00, to_int(ccfg[i].p_4ma, ccfg[i].tunit, ccfg[i].src)});
			p2 = signed'({2'b00, to_int(ccfg[i].p_20ma, ccfg[i].tunit, ccfg[i].src)});
			if (p1 == p2) begin
				q = '0;
			end else begin
				// signed slope: p1 above p2 gives a falling current
				q = (64'(signed'({2'b00, damp[i]}) - p1) * 64'(signed'({1'b0, fom_pkg::CUR_SPAN_UA})))
					/ 64'(p2 - p1);
			end
			if (q < 64'sd0) begin
				next_cur[i] = fom_pkg::CUR_4MA_UA;
			end else if (q > 64'(fom_pkg::CUR_SPAN_UA)) begin
				next_cur[i] = fom_pkg::CUR_20MA_UA;
			end else begin
				next_cur[i] = fom_pkg::CUR_4MA_UA + 16'(q);
			end
			if (device_fault || (ccfg[i].diag_en && next_err)) begin
				next_cur[i] = fom_pkg::CUR_22MA_UA;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			damp               <= '{default: '0};
			current_output_one <= fom_pkg::CUR_4MA_UA;
			current_output_two <= fom_pkg::CUR_4MA_UA;
		end else begin
			damp               <= next_damp;
			current_output_one <= next_cur[0];
			current_output_two <= next_cur[1];
		end
	end

	// ---- switch outputs ----
	fom_switch u_sw_one (
		.clk        (clk),
		.rstn       (rstn),
		.tick       (tick),
		.cfg        (sw_cfg_one),
		.value      (pick(sw_cfg_one.src, flow_rate, input_freq, total_one, total_two)),
		.low        (to_int(sw_cfg_one.low, sw_cfg_one.tunit, sw_cfg_one.src)),
		.high       (to_int(sw_cfg_one.high, sw_cfg_one.tunit, sw_cfg_one.src)),
		.warn       (warning_event),
		.sens_level (sensor_in),
		.sens_rise  (sens_rise),
		.ratio      (ratio[0]),
		.forced     (pulse_setting_forced_warning[0]),
		.sw_out     (switch_output_one)
	);

	fom_switch u_sw_two (
		.clk        (clk),
		.rstn       (rstn),
		.tick       (tick),
		.cfg        (sw_cfg_two),
		.value      (pick(sw_cfg_two.src, flow_rate, input_freq, total_one, total_two)),
		.low        (to_int(sw_cfg_two.low, sw_cfg_two.tunit, sw_cfg_two.src)),
		.high       (to_int(sw_cfg_two.high, sw_cfg_two.tunit, sw_cfg_two.src)),
		.warn       (warning_event),
		.sens_level (sensor_in),
		.sens_rise  (sens_rise),
		.ratio      (ratio[1]),
		.forced     (pulse_setting_forced_warning[1]),
		.sw_out     (switch_output_two)
	);

	AST_DISP_LIMIT: assert property (@(posedge clk) disable iff (!rstn)
		display_value <= fom_pkg::DISP_MAX)
		else $error("displayed value above four digits");

	AST_WIRE_NPN: assert property (@(posedge clk) disable iff (!rstn)
		npn_variant |=> wiring_sink)
		else $error("npn variant left in source wiring");

	AST_FAULT_22MA: assert property (@(posedge clk) disable iff (!rstn)
		device_fault |=> (current_output_one == fom_pkg::CUR_22MA_UA &&
		current_output_two == fom_pkg::CUR_22MA_UA))
		else $error("malfunction did not drive 22 mA");

	AST_DIAG_22MA: assert property (@(posedge clk) disable iff (!rstn)
		(cur_cfg_one.diag_en && next_err) |=> current_output_one == fom_pkg::CUR_22MA_UA)
		else $error("diagnostic error did not drive 22 mA");

	AST_CUR_RANGE: assert property (@(posedge clk) disable iff (!rstn)
		(!device_fault && !next_err) |=> (current_output_one >= fom_pkg::CUR_4MA_UA &&
		current_output_one <= fom_pkg::CUR_20MA_UA))
		else $error("current outside 4-20 mA without error");

	AST_PULSE_BIG: assert property (@(posedge clk) disable iff (!rstn)
		(sw_cfg_one.mode == fom_pkg::SW_PULSE && prod[0] > fom_pkg::PULSE_PROD_MAX)
		|=> (pulse_setting_too_large_warning[0] && warning_event))
		else $error("oversized pulse setting not warned");

	AST_FREQ_WARN: assert property (@(posedge clk) disable iff (!rstn)
		(freq_mon.en && input_freq > freq_mon.warn_hi) |=> warning_event)
		else $error("frequency above warn limit not warned");

	AST_MINMAX_ORDER: assert property (@(posedge clk) disable iff (!rstn)
		(!minmax_clear && mx != fom_pkg::MINMAX_RST_MAX) |=> mn <= mx)
		else $error("minimum above maximum");
endmodule

// File: test/fom_plant.sv
// plant side model: counts switch pulses seen on one switch pin
// assumes the pin is sampled on the device clock
`timescale 1ns/1ps
module fom_plant (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic sw_pin,
	output int        pulses
);
	logic prev; // last pin level

	// count rising edges of the pin
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev <= 1'b0;
			pulses <= 0;
		end else begin
			prev <= sw_pin;
			if (sw_pin && !prev) begin
				pulses <= pulses + 1;
			end
		end
	end
endmodule

// File: test/test_flow_output_mapping.sv
// random and corner tests of the flow output mapping top
// assumes a short tick of 4 cycles
`timescale 1ns/1ps
module test_flow_output_mapping;
	logic                   clk, rstn, sens, fault, clr, sel, npn, shown, sink, sw1, sw2;
	logic                   warn, err;
	logic [31:0]            flow, freq, t1, t2, kf, dv, mn, mx;
	logic [6:0]             con, bl, dcon, dbl;
	logic [15:0]            i1, i2;
	logic [1:0]             big, frc;
	fom_pkg::fom_mon_cfg_s  mon;
	fom_pkg::fom_disp_cfg_s dc, mc;
	fom_pkg::fom_cur_cfg_s  c1, c2;
	fom_pkg::fom_sw_cfg_s   s1, s2;
	int                     fails, total_checks, pulses, base;

	fom_output_map #(.TICK_CYCLES(4)) u_dut (.clk(clk), .rstn(rstn), .flow_rate(flow),
		.input_freq(freq), .total_one(t1), .total_two(t2), .sensor_in(sens), .k_factor(kf),
		.device_fault(fault), .freq_mon(mon), .disp_cfg(dc), .minmax_cfg(mc),
		.minmax_clear(clr), .contrast(con), .backlight(bl), .output_wiring_select(sel),
		.npn_variant(npn), .cur_cfg_one(c1), .cur_cfg_two(c2), .sw_cfg_one(s1),
		.sw_cfg_two(s2), .display_value(dv), .min_value(mn), .max_value(mx),
		.minmax_shown(shown), .disp_contrast(dcon), .disp_backlight(dbl), .wiring_sink(sink),
		.current_output_one(i1), .current_output_two(i2), .switch_output_one(sw1),
		.switch_output_two(sw2), .warning_event(warn), .error_event(err),
		.pulse_setting_too_large_warning(big), .pulse_setting_forced_warning(frc));
	fom_plant u_plant (.clk(clk), .rstn(rstn), .sw_pin(sw1), .pulses(pulses));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// wait n edges, then let updates settle
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// expected current in uA
	function automatic logic [15:0] cur(input longint v, input longint p1, input longint p2);
		longint q;
		if (p1 == p2) return 16'h0FA0;
		q = (v - p1) * 16000 / (p2 - p1);
		if (q < 0) q = 0;
		if (q > 16000) q = 16000;
		return 16'(4000 + q);
	endfunction

	// verdict and end of run
	task automatic conclude();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		conclude();
	end

	initial begin
		void'($urandom(32'h22df));
		{rstn, sens, fault, clr, sel, npn} = '0;
		{flow, freq, t1, t2, kf, con, bl} = '0;
		mon = '0;
		dc = '{1'b1, fom_pkg::SRC_FLOW, fom_pkg::TU_H};
		mc = '0;
		c1 = '0;
		c2 = '0;
		s1 = '{fom_pkg::SRC_FLOW, fom_pkg::SW_HYST, fom_pkg::TU_H, 0, 32'hFFFF_FFFF, 0, 0, 0};
		s2 = s1;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		w(2);
		chk(sink, 1);
		// display clamp, random flows and boundaries
		for (int i = 0; i < 6; i++) begin
			flow <= (i == 0) ? 9999 : (i == 1) ? 10000 : $urandom % 20000;
			w(3);
			chk(dv, (flow > 9999) ? 9999 : flow);
		end
		// min and max since clear
		mc <= '{1'b1, fom_pkg::SRC_FLOW, fom_pkg::TU_H};
		clr <= 1'b1;
		w(2);
		clr <= 1'b0;
		flow <= 500;
		w(2);
		flow <= 3000;
		w(2);
		flow <= 1200;
		w(3);
		chk(mn, 500);
		chk(mx, 3000);
		mc.en <= 1'b0;
		w(2);
		chk(shown, 0);
		// display settings
		con <= 7'($urandom % 101);
		bl <= 7'($urandom % 101);
		w(2);
		chk(dcon, con);
		chk(dbl, bl);
		// every wiring combination
		for (int i = 0; i < 4; i++) begin
			{npn, sel} <= 2'(i);
			w(2);
			chk(sink, 32'(npn || !sel));
		end
		// current mapping, normal and inverted
		c1 <= '{fom_pkg::SRC_FLOW, fom_pkg::TU_H, 1000, 3000, fom_pkg::DAMP_NONE, 1'b1};
		c2 <= '{fom_pkg::SRC_FREQ, fom_pkg::TU_H, 3000, 1000, fom_pkg::DAMP_NONE, 1'b0};
		for (int i = 0; i < 4; i++) begin
			flow <= 1000 + $urandom % 2000;
			freq <= 1000 + $urandom % 2000;
			w(3);
			chk(i1, cur(flow, 1000, 3000));
			chk(i2, cur(freq, 3000, 1000));
		end
		fault <= 1'b1;
		w(2);
		chk({i1, i2}, {16'h55F0, 16'h55F0});
		fault <= 1'b0;
		// frequency monitor events
		mon <= '{1'b1, 100, 10, 200, 5};
		freq <= 150;
		w(3);
		chk({warn, err}, 2'b10);
		freq <= 250;
		w(3);
		chk({warn, err}, 2'b11);
		chk(i1, 16'h55F0);
		chk(i2, cur(250, 3000, 1000));
		// switch linked to warnings
		s1.src <= fom_pkg::SRC_WARN;
		freq <= 8;
		w(3);
		chk(sw1, 1);
		freq <= 50;
		w(3);
		chk(sw1, 0);
		mon.en <= 1'b0;
		// hysteresis with both rest senses
		for (int nc = 0; nc < 2; nc++) begin
			s1 <= '{fom_pkg::SRC_FLOW, fom_pkg::SW_HYST, fom_pkg::TU_H, 1000, 2000, 1'(nc), 0, 0};
			flow <= 1500;
			w(20);
			chk(sw1, nc);
			flow <= 2000;
			w(20);
			chk(sw1, 32'(!nc));
			flow <= 1500;
			w(20);
			chk(sw1, 32'(!nc));
			flow <= 1000;
			w(20);
			chk(sw1, nc);
		end
		// one second delay before switching
		s1.nc <= 1'b0;
		s1.delay_s <= 6'h01;
		flow <= 2000;
		w(100);
		chk(sw1, 0);
		w(4100);
		chk(sw1, 1);
		// window mode
		s1.delay_s <= 6'h00;
		s1.mode <= fom_pkg::SW_WINDOW;
		flow <= 1500;
		w(20);
		chk(sw1, 1);
		flow <= 2500;
		w(20);
		chk(sw1, 0);
		// second switch on a totalizer, window mode, normally closed
		s2 <= '{fom_pkg::SRC_TOT1, fom_pkg::SW_WINDOW, fom_pkg::TU_H, 100, 200, 1'b1, 0, 0};
		t1 <= 150;
		w(20);
		chk(sw2, 0);
		t1 <= 300;
		w(20);
		chk(sw2, 1);
		// pulse mode settings out of range
		s1.mode <= fom_pkg::SW_PULSE;
		s1.pulse_vol <= 2000;
		kf <= 1000000;
		w(3);
		chk({big[0], warn}, 2'b11);
		kf <= 0;
		sens <= 1'b1;
		w(3);
		chk({frc[0], sw1}, 2'b11);
		sens <= 1'b0;
		w(2);
		chk(sw1, 0);
		// four sensor edges make one pulse
		kf <= 2;
		w(60);
		base = pulses;
		repeat (4) begin
			sens <= 1'b1;
			w(2);
			sens <= 1'b0;
			w(2);
		end
		w(60);
		chk(pulses - base, 1);
		conclude();
	end
endmodule
